// [rtl/reset_pulse_gen.sv]
// reset output driver: open-drain release, configured level, timed pulse or held level
module reset_pulse_gen
  import sec_pins_pkg::*;
(
  input  wire logic        hclk,       // system clock
  input  wire logic        hresetn,    // async reset, active low
  input  wire logic        us_tick,    // one-cycle microsecond enable
  input  wire logic        enable,     // output function enabled
  input  wire logic        level_high, // drive high when set, low otherwise
  input  wire logic        hold_mode,  // keep asserted instead of pulsing
  input  wire logic        trigger,    // selected event, one cycle
  input  wire logic [15:0] dur_us,     // pulse length in microseconds
  output logic             pin_out,    // level driven while active
  output logic             pin_oe,     // high while the pin is driven
  output logic             active      // pulse or hold in progress
);

  logic        act_reg;
  logic        act_next;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic        lvl_reg;

  // pulse timer; disabling always releases, which also ends a held level
  always_comb begin
    act_next = act_reg;
    cnt_next = cnt_reg;
    if (!enable) begin
      act_next = 1'b0;
    end else if (trigger) begin
      act_next = 1'b1;
      cnt_next = dur_us;
    end else if (act_reg && !hold_mode && us_tick) begin
      if (cnt_reg <= 16'h0001) begin
        act_next = 1'b0;
      end else begin
        cnt_next = cnt_reg - 16'h0001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_reg <= 1'b0;
      cnt_reg <= 16'h0000;
      lvl_reg <= 1'b0;
    end else begin
      act_reg <= act_next;
      cnt_reg <= cnt_next;
      lvl_reg <= level_high;
    end
  end

  // undriven except during the event: open drain at all other times
  assign pin_oe  = act_reg;
  assign pin_out = lvl_reg;
  assign active  = act_reg;

endmodule

// [rtl/security_ctrl_status_pins.sv]
// control and status pins of the security coprocessor, with an ahb-lite register slave
//
// Overview of operation
// - low tamper input launches response when enabled
// - tamper detect off after reset, input ignored
// - tamper counted only powered, pin high, valid
// - tamper action selectable, including key zeroize
// - reset output disabled after reset, not driven
// - enabled reset output undriven except during event
// - event drives level for set time or holds
// - watchdog off after reset, kick input ignored
// - ready low while busy or not accepting
// - ready high once boot done and accepting
// - ready high when response available for host
// - power-down pin low erases all volatile state
//
// Our own choices: the register addresses and register access over AHB-Lite.
module security_ctrl_status_pins
  import sec_pins_pkg::*;
(
  input  wire logic        hclk,                  // system clock, 20 MHz
  input  wire logic        hresetn,               // async reset, active low
  input  wire logic        hsel,                  // slave select from decoder
  input  wire logic [31:0] haddr,                 // byte address
  input  wire logic [1:0]  htrans,                // transfer type
  input  wire logic        hwrite,                // write when high
  input  wire logic [2:0]  hsize,                 // only word writes act; reads of any size
  input  wire logic [31:0] hwdata,                // write data
  input  wire logic        hready,                // bus ready in
  output logic             hreadyout,             // slave ready out
  output logic             hresp,                 // always okay
  output logic [31:0]      hrdata,                // read data
  input  wire logic        tamper_sense_n,        // tamper sensor, active low
  input  wire logic        op_valid,              // operating conditions valid
  input  wire logic        power_down_pin,        // low requests power-down
  input  wire logic        watchdog_kick_input,   // kick from host, any edge
  input  wire logic        serial_port_select_n,  // serial select, active low
  input  wire logic        cmd_done,              // engine finished, one cycle
  input  wire logic        reset_out_in,          // sensed level of reset pin
  output logic             reset_out_out,         // driven level of reset pin
  output logic             reset_out_oe,          // reset pin drive enable
  output logic             ready_out,             // ready pin level
  output logic             zeroize_keys,          // wipe secret keys, one cycle
  output logic             volatile_clear         // erase volatile data, level
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic                 powered;
  logic                 bus_take;
  logic                 word_ok;
  logic                 wr_pend_reg;
  logic                 rd_pend_reg;
  logic [ADDR_W-1:0]    acc_addr_reg;
  logic                 hready_reg;
  logic [31:0]          hrdata_reg;
  logic                 wr_go;
  logic                 wr_ctrl;
  logic                 wr_dur;
  logic                 wr_to;
  logic                 wr_status;
  logic [31:0]          rd_mux;
  logic [31:0]          status_word;
  logic [CTRL_W-1:0]    ctrl_reg;
  logic [15:0]          rsto_dur_reg;
  logic [15:0]          wdt_to_reg;
  logic [4:0]           div_reg;
  logic                 us_tick;
  logic                 tamper_cond;
  logic                 tamper_prev_reg;
  logic                 tamper_event;
  logic                 zeroize_reg;
  logic                 kick_prev_reg;
  logic                 kick_edge;
  logic                 wdt_run;
  logic [15:0]          wdt_cnt_reg;
  logic                 wdt_event;
  logic                 rsto_trigger;
  logic                 rsto_active;
  logic [NUM_FLAGS-1:0] flag_reg;
  logic [NUM_FLAGS-1:0] flag_set;
  logic [NUM_FLAGS-1:0] flag_clr;
  logic                 sel_prev_reg;
  logic                 sel_fall;
  logic [7:0]           boot_cnt_reg;
  logic [7:0]           boot_cnt_next;
  rdy_state_type        state_reg;
  rdy_state_type        state_next;
  logic                 ready_reg;
  logic                 vclr_reg;

  // ----------------------------------------------------------------
  // bus slave: writes land in the data phase, reads take one wait
  // ----------------------------------------------------------------

  // the wait state on reads lets a write just before a read land first
  assign powered  = power_down_pin;
  assign bus_take = hsel && htrans[1] && hready && hready_reg;
  assign word_ok  = (hsize == HSIZE_WORD);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg  <= 1'b0;
      rd_pend_reg  <= 1'b0;
      acc_addr_reg <= CTRL_OFS;
      hready_reg   <= 1'b1;
    end else begin
      wr_pend_reg  <= bus_take && hwrite && word_ok;
      rd_pend_reg  <= bus_take && !hwrite;
      hready_reg   <= !(bus_take && !hwrite);
      if (bus_take) begin
        acc_addr_reg <= {haddr[ADDR_W-1:2], 2'b00};
      end
    end
  end

  // read data is loaded during the wait cycle; unmapped reads give zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (rd_pend_reg) begin
      hrdata_reg <= rd_mux;
    end
  end

  assign hreadyout = hready_reg;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;

  // write decode; writes are dropped while powered down
  assign wr_go     = wr_pend_reg && powered;
  assign wr_ctrl   = wr_go && (acc_addr_reg == CTRL_OFS);
  assign wr_dur    = wr_go && (acc_addr_reg == RSTO_DUR_OFS);
  assign wr_to     = wr_go && (acc_addr_reg == WDT_TO_OFS);
  assign wr_status = wr_go && (acc_addr_reg == STATUS_OFS);

  // read selection
  assign status_word = {26'h000_0000, rsto_active, powered, ready_reg, flag_reg};
  assign rd_mux = (acc_addr_reg == CTRL_OFS)     ? {24'h00_0000, ctrl_reg} :
                  (acc_addr_reg == RSTO_DUR_OFS) ? {16'h0000, rsto_dur_reg} :
                  (acc_addr_reg == WDT_TO_OFS)   ? {16'h0000, wdt_to_reg} :
                  (acc_addr_reg == STATUS_OFS)   ? status_word :
                  32'h0000_0000;

  // ----------------------------------------------------------------
  // configuration registers, erased by power-down
  // ----------------------------------------------------------------

  // every function starts disabled: tamper, watchdog and reset output
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= CTRL_RESET;
    end else if (!powered) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= hwdata[CTRL_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rsto_dur_reg <= RSTO_DUR_RESET;
      wdt_to_reg   <= WDT_TO_RESET;
    end else if (!powered) begin
      rsto_dur_reg <= RSTO_DUR_RESET;
      wdt_to_reg   <= WDT_TO_RESET;
    end else begin
      if (wr_dur) begin
        rsto_dur_reg <= hwdata[15:0];
      end
      if (wr_to) begin
        wdt_to_reg <= hwdata[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // microsecond enable
  // ----------------------------------------------------------------

  // one divider serves the watchdog, the pulse timer and boot delay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_reg <= 5'h00;
    end else if (div_reg == US_DIV_LAST) begin
      div_reg <= 5'h00;
    end else begin
      div_reg <= div_reg + 5'h01;
    end
  end

  assign us_tick = (div_reg == US_DIV_LAST);

  // ----------------------------------------------------------------
  // tamper detection
  // ----------------------------------------------------------------

  // a held-low sensor launches one response, not one per cycle
  assign tamper_cond  = ctrl_reg[CTRL_TAMPER_EN] && !tamper_sense_n;
  assign tamper_event = tamper_cond && !tamper_prev_reg && powered && op_valid;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tamper_prev_reg <= 1'b0;
      zeroize_reg     <= 1'b0;
    end else begin
      tamper_prev_reg <= tamper_cond && powered && op_valid;
      zeroize_reg     <= tamper_event && ctrl_reg[CTRL_TAMP_ZERO];
    end
  end

  assign zeroize_keys = zeroize_reg;

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------

  // any transition of the kick input restarts the timeout
  assign kick_edge = watchdog_kick_input ^ kick_prev_reg;
  assign wdt_run   = ctrl_reg[CTRL_WDT_EN] && powered;
  assign wdt_event = wdt_run && !kick_edge && us_tick
                     && (wdt_cnt_reg >= wdt_to_reg - 16'h0001);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      kick_prev_reg <= 1'b0;
      wdt_cnt_reg   <= 16'h0000;
    end else begin
      kick_prev_reg <= watchdog_kick_input;
      if (!wdt_run || kick_edge || wdt_event) begin
        wdt_cnt_reg <= 16'h0000;
      end else if (us_tick) begin
        wdt_cnt_reg <= wdt_cnt_reg + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // reset output
  // ----------------------------------------------------------------

  // events are routed to the pin only where software selected them
  assign rsto_trigger = (tamper_event && ctrl_reg[CTRL_TAMP_RSTO])
                        || (wdt_event && ctrl_reg[CTRL_WDT_RSTO]);

  reset_pulse_gen u_rsto (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .us_tick    (us_tick),
    .enable     (ctrl_reg[CTRL_RSTO_EN]),
    .level_high (ctrl_reg[CTRL_RSTO_HIGH]),
    .hold_mode  (ctrl_reg[CTRL_RSTO_HOLD]),
    .trigger    (rsto_trigger),
    .dur_us     (rsto_dur_reg),
    .pin_out    (reset_out_out),
    .pin_oe     (reset_out_oe),
    .active     (rsto_active)
  );

  // ----------------------------------------------------------------
  // sticky status flags: set wins over a write-one clear
  // ----------------------------------------------------------------
  assign flag_set = {zeroize_reg, wdt_event, tamper_event};
  assign flag_clr = wr_status ? hwdata[NUM_FLAGS-1:0] : {NUM_FLAGS{1'b0}};

  generate
    for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          flag_reg[i] <= 1'b0;
        end else if (!powered) begin
          flag_reg[i] <= 1'b0;
        end else if (flag_set[i]) begin
          flag_reg[i] <= 1'b1;
        end else if (flag_clr[i]) begin
          flag_reg[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // ready sequencer
  // ----------------------------------------------------------------

  // a select that goes low is where command reception begins
  assign sel_fall = sel_prev_reg && !serial_port_select_n;

  always_comb begin
    state_next    = state_reg;
    boot_cnt_next = boot_cnt_reg;
    unique case (state_reg)
      RDY_DOWN: begin
        boot_cnt_next = 8'h00;
        if (powered) begin
          state_next = RDY_BOOT;
        end
      end
      RDY_BOOT: begin
        if (us_tick) begin
          if (boot_cnt_reg == BOOT_LAST) begin
            state_next = RDY_IDLE;
          end else begin
            boot_cnt_next = boot_cnt_reg + 8'h01;
          end
        end
      end
      RDY_IDLE: begin
        if (sel_fall) begin
          state_next = RDY_BUSY;
        end
      end
      RDY_BUSY: begin
        if (cmd_done) begin
          state_next = RDY_IDLE;
        end
      end
    endcase
    if (!powered) begin
      state_next = RDY_DOWN;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg    <= RDY_BOOT;
      boot_cnt_reg <= 8'h00;
      sel_prev_reg <= 1'b1;
      ready_reg    <= 1'b0;
      vclr_reg     <= 1'b0;
    end else begin
      state_reg    <= state_next;
      boot_cnt_reg <= boot_cnt_next;
      sel_prev_reg <= serial_port_select_n;
      ready_reg    <= (state_next == RDY_IDLE);
      vclr_reg     <= !powered;
    end
  end

  assign ready_out      = ready_reg;
  assign volatile_clear = vclr_reg;

  // sensed reset pin level is not used: the pin is output only here
  logic unused_ok;
  assign unused_ok = reset_out_in ^ haddr[31] ^ htrans[0];

endmodule

// [shared/sec_pins_pkg.sv]
// package: register map, field positions, reset values and timing for the control pins
package sec_pins_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned US_NS         = 1000;
  localparam int unsigned US_DIV_CYCLES = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BOOT_TIME_US  = 10;
  localparam logic [4:0]  US_DIV_LAST   = 5'(US_DIV_CYCLES - 1);
  localparam logic [7:0]  BOOT_LAST     = 8'(BOOT_TIME_US - 1);

  // ----------------------------------------------------------------
  // register offsets (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam int unsigned  ADDR_W      = 12;
  localparam logic [11:0]  CTRL_OFS    = 12'h000;
  localparam logic [11:0]  RSTO_DUR_OFS = 12'h004;
  localparam logic [11:0]  WDT_TO_OFS  = 12'h008;
  localparam logic [11:0]  STATUS_OFS  = 12'h00C;
  localparam logic [2:0]   HSIZE_WORD  = 3'h2;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_W          = 8;
  localparam int unsigned CTRL_TAMPER_EN  = 0;
  localparam int unsigned CTRL_WDT_EN     = 1;
  localparam int unsigned CTRL_RSTO_EN    = 2;
  localparam int unsigned CTRL_RSTO_HIGH  = 3;
  localparam int unsigned CTRL_RSTO_HOLD  = 4;
  localparam int unsigned CTRL_TAMP_ZERO  = 5;
  localparam int unsigned CTRL_TAMP_RSTO  = 6;
  localparam int unsigned CTRL_WDT_RSTO   = 7;
  localparam logic [7:0]  CTRL_RESET      = 8'h00;
  localparam logic [15:0] RSTO_DUR_RESET  = 16'h000A;
  localparam logic [15:0] WDT_TO_RESET    = 16'h03E8;

  // ----------------------------------------------------------------
  // status fields: sticky flags in the low bits, live state above
  // ----------------------------------------------------------------
  localparam int unsigned NUM_FLAGS       = 3;
  localparam int unsigned ST_TAMPER       = 0;
  localparam int unsigned ST_WDT          = 1;
  localparam int unsigned ST_ZEROIZED     = 2;
  localparam int unsigned ST_READY        = 3;
  localparam int unsigned ST_POWERED      = 4;
  localparam int unsigned ST_RSTO_ACTIVE  = 5;

  // ready sequencer, gray coded along down -> boot -> idle <-> busy
  typedef enum logic [1:0] {
    RDY_BOOT = 2'h0,
    RDY_IDLE = 2'h1,
    RDY_BUSY = 2'h3,
    RDY_DOWN = 2'h2
  } rdy_state_type;

endpackage

// [verification/host_model.sv]
// host model: power-down pin, serial select and watchdog kicks
module host_model (
  input  wire logic hclk,                 // system clock
  output logic      power_down_pin,       // high while talking
  output logic      serial_port_select_n, // select, active low
  output logic      watchdog_kick_input   // kick line
);
  timeunit 1ns;
  timeprecision 1ns;

  // power-down and select high, kick low before any traffic, device awake
  initial begin
    power_down_pin = 1'b1;
    serial_port_select_n = 1'b1;
    watchdog_kick_input = 1'b0;
  end

  // select held low for a whole frame of n cycles
  task automatic select_cmd(input int n);
    @(posedge hclk);
    serial_port_select_n <= 1'b0;
    repeat (n) @(posedge hclk);
    serial_port_select_n <= 1'b1;
  endtask

  // any edge counts, so toggling is a kick
  task automatic kick();
    @(posedge hclk);
    watchdog_kick_input <= ~watchdog_kick_input;
  endtask

  task automatic power(input logic v);
    @(posedge hclk);
    power_down_pin <= v;
  endtask
endmodule

// [verification/sec_pins_chk.sv]
// checker: port timing of the ready, tamper, reset-out and power-down pins
module sec_pins_chk (
  input wire logic hclk,                 // system clock
  input wire logic hresetn,              // async reset, active low
  input wire logic hresp,                // bus response
  input wire logic serial_port_select_n, // serial select, active low
  input wire logic cmd_done,             // engine finished
  input wire logic ready_out,            // ready pin
  input wire logic power_down_pin,       // low = power-down
  input wire logic volatile_clear,       // erase level
  input wire logic zeroize_keys,         // key wipe pulse
  input wire logic tamper_sense_n,       // tamper sensor
  input wire logic op_valid,             // conditions valid
  input wire logic reset_out_oe          // reset pin drive enable
);
  timeunit 1ns;
  timeprecision 1ns;

  logic busy_reg;  // command taken, answer pending

  // mirror of the busy phase; ready high stands for the idle state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_reg <= 1'b0;
    end else if ($fell(serial_port_select_n) && ready_out && power_down_pin) begin
      busy_reg <= 1'b1;
    end else if (!power_down_pin || cmd_done) begin
      busy_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  hresp_okay_a:
    assert property (hresp == 1'b0) else $error("hresp not okay");
  ready_drop_a:
    assert property ($fell(serial_port_select_n) && ready_out && power_down_pin |=> !ready_out)
      else $error("ready did not drop on select");
  ready_busy_a:
    assert property (busy_reg && !cmd_done && power_down_pin |=> !ready_out)
      else $error("ready high while busy");
  ready_done_a:
    assert property (busy_reg && cmd_done && power_down_pin |=> ready_out)
      else $error("ready not raised after done");
  pd_clear_a:
    assert property (!power_down_pin |=> volatile_clear && !ready_out)
      else $error("power-down not honoured");
  pd_exit_a:
    assert property (power_down_pin |=> !volatile_clear) else $error("clear stuck");
  zero_pulse_a:
    assert property (zeroize_keys |=> !zeroize_keys) else $error("zeroize too long");
  tamper_gate_a:
    assert property (zeroize_keys |-> $past(!tamper_sense_n && power_down_pin && op_valid))
      else $error("zeroize without valid tamper");
  rsto_pd_a:
    assert property (!power_down_pin [*3] |=> !reset_out_oe)
      else $error("reset pin driven in power-down");
endmodule

bind security_ctrl_status_pins sec_pins_chk i_chk (
  .hclk, .hresetn, .hresp, .serial_port_select_n, .cmd_done, .ready_out,
  .power_down_pin, .volatile_clear, .zeroize_keys, .tamper_sense_n, .op_valid,
  .reset_out_oe
);

// [verification/security_ctrl_status_pins_tb.sv]
// testbench: bus access, ready handshake, tamper, watchdog and power-down
module security_ctrl_status_pins_tb
  import sec_pins_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic        hclk, hresetn, hsel, hwrite, tamper_sense_n, op_valid, cmd_done, rd_ph;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout, hresp, reset_out_out, reset_out_oe, ready_out;
  logic        zeroize_keys, volatile_clear, power_down_pin;
  logic        serial_port_select_n, watchdog_kick_input;
  logic [15:0] lf;
  wire         reset_out_in;
  logic [31:0] exp_q[$], msk_q[$];
  int          errors, tests_run, cyc;

  // pull-up holds the reset pin high when nobody drives it
  assign reset_out_in = reset_out_oe ? reset_out_out : 1'b1;

  security_ctrl_status_pins i_dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .tamper_sense_n, .op_valid,
    .power_down_pin, .watchdog_kick_input, .serial_port_select_n, .cmd_done,
    .reset_out_in, .reset_out_out, .reset_out_oe, .ready_out, .zeroize_keys,
    .volatile_clear
  );
  host_model i_host (.hclk, .power_down_pin, .serial_port_select_n, .watchdog_kick_input);

  always #(CLK_PERIOD_NS / 2) hclk = ~hclk;

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // one single transfer; every wait ends only on hready high
  task automatic ahb(input logic [11:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h0_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    rd_ph <= !w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_ph <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    ahb(a, 1'b0, 32'h0000_0000);
  endtask

  task automatic wait_ready();
    for (int i = 0; i < 400 && ready_out !== 1'b1; i++) @(posedge hclk);
  endtask

  task automatic count_oe(input int w, output int n, output logic lv);
    n = 0;
    lv = 1'bx;
    repeat (w) begin
      @(posedge hclk);
      if (reset_out_oe === 1'b1) begin
        n++;
        lv = reset_out_out;
      end
    end
  endtask

  // read data compared at the edge that ends the data phase
  always @(posedge hclk) begin
    if (rd_ph && hreadyout === 1'b1) begin
      check("hrdata", hrdata & msk_q.pop_front(), exp_q.pop_front());
    end
  end

  // hang guard, well above the few thousand cycles the run needs
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int   n;
    logic lv;
    hclk = 1'b0;
    hresetn = 1'b0;
    {hsel, hwrite, rd_ph, cmd_done, haddr, htrans, hwdata} = '0;
    hsize = HSIZE_WORD;
    tamper_sense_n = 1'b1;
    op_valid = 1'b1;
    lf = 16'h9087;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(CTRL_OFS, 32'h0000_0000, ALL);
    rd(RSTO_DUR_OFS, 32'h0000_000A, ALL);
    rd(WDT_TO_OFS, 32'h0000_03E8, ALL);
    rd(STATUS_OFS, 32'h0000_0010, ALL);
    rd(12'h010, 32'h0000_0000, ALL);
    lf = lfsr(lf);
    ahb(RSTO_DUR_OFS, 1'b1, {16'hFFFF, lf});
    rd(RSTO_DUR_OFS, {16'h0000, lf}, ALL);
    wait_ready();
    rd(STATUS_OFS, 32'h0000_0018, ALL);
    $display("test reset and boot done");
    // command: ready drops, a second frame while busy is ignored
    fork i_host.select_cmd(4); join_none
    repeat (3) @(posedge hclk);
    rd(STATUS_OFS, 32'h0000_0000, 32'h0000_0008);
    i_host.select_cmd(2);
    rd(STATUS_OFS, 32'h0000_0000, 32'h0000_0008);
    cmd_done <= 1'b1;
    @(posedge hclk);
    cmd_done <= 1'b0;
    @(posedge hclk);
    rd(STATUS_OFS, 32'h0000_0008, 32'h0000_0008);
    $display("test ready handshake done");
    // tamper ignored while disabled, then while conditions invalid
    tamper_sense_n <= 1'b0;
    repeat (3) @(posedge hclk);
    tamper_sense_n <= 1'b1;
    rd(STATUS_OFS, 32'h0000_0000, 32'h0000_0007);
    ahb(CTRL_OFS, 1'b1, 32'h0000_0065);
    ahb(RSTO_DUR_OFS, 1'b1, 32'h0000_0003);
    op_valid <= 1'b0;
    tamper_sense_n <= 1'b0;
    repeat (3) @(posedge hclk);
    tamper_sense_n <= 1'b1;
    rd(STATUS_OFS, 32'h0000_0000, 32'h0000_0007);
    op_valid <= 1'b1;
    tamper_sense_n <= 1'b0;
    count_oe(300, n, lv);
    tamper_sense_n <= 1'b1;
    check("pulse_len", 32'(n >= 2 * US_DIV_CYCLES && n <= 3 * US_DIV_CYCLES + 1), 1);
    check("pulse_level", {31'h0, lv}, 32'h0000_0000);
    rd(STATUS_OFS, 32'h0000_0005, 32'h0000_0005);
    ahb(STATUS_OFS, 1'b1, 32'h0000_0007);
    rd(STATUS_OFS, 32'h0000_0000, 32'h0000_0007);
    // held high level until the output function is switched off
    ahb(CTRL_OFS, 1'b1, 32'h0000_005D);
    tamper_sense_n <= 1'b0;
    count_oe(300, n, lv);
    check("hold_len", 32'(n >= 298), 1);
    check("hold_level", {31'h0, lv}, 32'h0000_0001);
    ahb(CTRL_OFS, 1'b1, 32'h0000_0000);
    tamper_sense_n <= 1'b1;
    @(posedge hclk); // pin lets go one cycle after the write lands
    count_oe(50, n, lv);
    check("released", 32'(n), 0);
    $display("test tamper and reset output done");
    // watchdog kept alive by kicks, then starved
    ahb(WDT_TO_OFS, 1'b1, 32'h0000_0005);
    ahb(CTRL_OFS, 1'b1, 32'h0000_0086);
    for (int i = 0; i < 15; i++) begin
      i_host.kick();
      repeat (40) @(posedge hclk);
    end
    rd(STATUS_OFS, 32'h0000_0000, 32'h0000_0002);
    count_oe(200, n, lv);
    check("wdt_pulse", 32'(n > 0), 1);
    rd(STATUS_OFS, 32'h0000_0002, 32'h0000_0002);
    ahb(CTRL_OFS, 1'b1, 32'h0000_0084);
    ahb(STATUS_OFS, 1'b1, 32'h0000_0007);
    repeat (300) @(posedge hclk);
    rd(STATUS_OFS, 32'h0000_0000, 32'h0000_0002);
    $display("test watchdog done");
    // power-down wipes state and refuses writes
    i_host.power(1'b0);
    repeat (3) @(posedge hclk);
    ahb(CTRL_OFS, 1'b1, 32'h0000_0002);
    rd(CTRL_OFS, 32'h0000_0000, ALL);
    rd(STATUS_OFS, 32'h0000_0000, 32'h0000_0018);
    i_host.power(1'b1);
    wait_ready();
    rd(STATUS_OFS, 32'h0000_0018, 32'h0000_0018);
    rd(RSTO_DUR_OFS, 32'h0000_000A, ALL);
    $display("test power-down done");
    repeat (3) @(posedge hclk);
    final_report();
  end
endmodule
